/* File: prsrs_consts.vh */
// constants for the panel run/stop/reset sequencer
`ifndef PRSRS_CONSTS_VH
`define PRSRS_CONSTS_VH
// clock rate in hertz
`define PRSRS_CLK_HZ 20000000
// timing figures, in milliseconds
`define PRSRS_FLASH_PERIOD_MS 1000
`define PRSRS_LONG_PRESS_MS 5000
`define PRSRS_SELECT_MS 20000
`define PRSRS_CONFIRM_MS 10000
`define PRSRS_ACK_PULSE_MS 250
`define PRSRS_DEBOUNCE_MS 20
// cycles per millisecond
`define PRSRS_CYC_PER_MS (`PRSRS_CLK_HZ / 1000)
// battery error report fields
`define PRSRS_ERR_CODE 16'h0B00
`define PRSRS_ERR_MODULE 8'h78
`define PRSRS_ERR_NUMBER 8'h01
// extended function codes
`define PRSRS_FUNC_NONE 2'h0
`define PRSRS_FUNC_ERASE_BLOCKS 2'h1
`define PRSRS_FUNC_RELOAD_PROJECT 2'h2
`endif

/* File: prsrs_sync_debounce.v */
// two-stage synchroniser followed by a stable-level debouncer
`timescale 1ns/10ps
module prsrs_sync_debounce #(
   parameter STABLE_CYC = 400
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // raw pin and clean level
   input wire pinIn,
   output reg levelOut
);
   reg sync1_r; // first stage, read only by the second
   reg sync2_r; // second stage
   reg [31:0] stableCnt_r; // cycles the level has differed

   // synchroniser and debounce counter
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         stableCnt_r <= 32'h00000000;
         levelOut <= 1'b0;
      end else begin
         sync1_r <= pinIn;
         sync2_r <= sync1_r;
         if (sync2_r == levelOut) begin
            // agrees with output: bounce window restarts
            stableCnt_r <= 32'h00000000;
         end else if (stableCnt_r >= STABLE_CYC - 1) begin
            // stable long enough, accept new level
            levelOut <= sync2_r; // [R14]
            stableCnt_r <= 32'h00000000;
         end else begin
            stableCnt_r <= stableCnt_r + 32'h00000001;
         end
      end
   end
endmodule // prsrs_sync_debounce

/* File: prsrs_timer.v */
// loadable down-counter that pulses once when it expires
`timescale 1ns/10ps
module prsrs_timer (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire load,
   input wire [31:0] loadVal,
   input wire stop,
   // status
   output wire running,
   output reg expired
);
   reg [31:0] count_r; // cycles left, zero when idle

   assign running = (count_r != 32'h00000000);

   // count down, pulse at the last cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 32'h00000000;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (stop) begin
            count_r <= 32'h00000000;
         end else if (load) begin
            count_r <= loadVal;
         end else if (count_r == 32'h00000001) begin
            count_r <= 32'h00000000;
            expired <= 1'b1;
         end else if (count_r != 32'h00000000) begin
            count_r <= count_r - 32'h00000001;
         end
      end
   end
endmodule // prsrs_timer

/* File: prsrs_panel.v */
// front-panel run/stop/reset sequencer with lamps and battery check
//
// Summary of operation
// [R01] fault lamp blinks, one second period
// [R02] halt lamp steady while halted
// [R03] run lamp off after inputs, on before outputs
// [R04] halt position suspends cyclic execution
// [R05] run position enables cyclic execution
// [R06] reset press resets, then runs automatically
// [R07] over five seconds lights extended lamp
// [R08] one press erases blocks, two reload
// [R09] lamp off, then one or two flashes
// [R10] after twenty seconds lamp steady ten
// [R11] function runs only if confirmed by press
// [R12] short press or timeout gives plain reset
// [R13] low battery reports error 2816/120/1
// [R14] switch inputs debounced before use
// [R15] count only in selection window, max two
`timescale 1ns/10ps
`include "prsrs_consts.vh"
module prsrs_panel #(
   parameter LONG_PRESS_CYC = `PRSRS_LONG_PRESS_MS * `PRSRS_CYC_PER_MS,
   parameter SELECT_CYC = `PRSRS_SELECT_MS * `PRSRS_CYC_PER_MS,
   parameter CONFIRM_CYC = `PRSRS_CONFIRM_MS * `PRSRS_CYC_PER_MS,
   parameter HALF_FLASH_CYC = (`PRSRS_FLASH_PERIOD_MS / 2) * `PRSRS_CYC_PER_MS,
   parameter ACK_CYC = `PRSRS_ACK_PULSE_MS * `PRSRS_CYC_PER_MS,
   parameter DEBOUNCE_CYC = `PRSRS_DEBOUNCE_MS * `PRSRS_CYC_PER_MS
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // operator switch pins, high when in that position
   input wire haltPosition,
   input wire runPosition,
   input wire resetPosition,
   // controller status, from same-clock logic
   input wire faultState,
   input wire inputImageDone,
   input wire outputImageStart,
   // battery comparator pin, high when low
   input wire batteryLow,
   // lamps
   output reg faultLamp,
   output reg haltLamp,
   output reg runLamp,
   output reg extendedFunctionLamp,
   // controller commands
   output reg cycleEnable,
   output reg resetPulse,
   output reg [1:0] extFunction,
   output reg extFunctionPulse,
   // battery error report
   output reg batteryError,
   output reg [15:0] errCode,
   output reg [7:0] errModule,
   output reg [7:0] errNumber
);
   // sequencer states
   localparam ST_IDLE = 3'h0; // halt or run
   localparam ST_PRESS = 3'h1; // reset held, timing long press
   localparam ST_WAIT_REL = 3'h2; // long press reached, waiting release
   localparam ST_SELECT = 3'h3; // counting selection presses
   localparam ST_CONFIRM = 3'h4; // lamp steady, waiting confirm
   localparam ST_DO_RESET = 3'h5; // issue reset then run

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [1:0] selCount_r; // selection presses so far
   reg selOver_r; // more than two presses seen
   reg resetPrev_r; // last debounced reset level
   reg [2:0] ackLeft_r; // ack half-pulses still to show
   reg [31:0] ackCnt_r; // half-pulse timer
   reg [31:0] flashCnt_r; // fault blink timer
   reg blink_r; // fault blink phase
   reg running_r; // controller in run state
   reg [1:0] batSync_r; // battery pin synchroniser

   wire haltDb;
   wire runDb;
   wire resetDb;
   wire resetRise;
   wire resetFall;
   wire tmrLoad;
   wire [31:0] tmrVal;
   wire tmrExpired;
   wire tmrRunning;

   // debounced switch levels
   prsrs_sync_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) uHalt (
      .clk(clk), .rst_n(rst_n), .pinIn(haltPosition), .levelOut(haltDb)); // [R14]
   prsrs_sync_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) uRun (
      .clk(clk), .rst_n(rst_n), .pinIn(runPosition), .levelOut(runDb));
   prsrs_sync_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) uReset (
      .clk(clk), .rst_n(rst_n), .pinIn(resetPosition), .levelOut(resetDb));

   assign resetRise = resetDb & ~resetPrev_r;
   assign resetFall = ~resetDb & resetPrev_r;

   // one shared timer serves each timed state in turn
   assign tmrLoad = (state_r != state_nxt) &&
                    (state_nxt == ST_PRESS || state_nxt == ST_SELECT ||
                     state_nxt == ST_CONFIRM);
   assign tmrVal = (state_nxt == ST_PRESS) ? LONG_PRESS_CYC :
                   (state_nxt == ST_SELECT) ? SELECT_CYC : CONFIRM_CYC;

   // the timer is cleared on every return to idle, so a stale count left
   // by a short press or a confirm can never expire into a later state
   prsrs_timer uTimer (
      .clk(clk),
      .rst_n(rst_n),
      .load(tmrLoad),
      .loadVal(tmrVal),
      .stop(state_r == ST_DO_RESET),
      .running(tmrRunning),
      .expired(tmrExpired)
   );

   // next-state logic
   // presses are edges of the debounced level, so chatter on the lever
   // can never start, count or confirm anything by itself
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (resetRise) begin
               state_nxt = ST_PRESS;
            end
         end
         ST_PRESS: begin
            if (resetFall) begin
               state_nxt = ST_DO_RESET; // [R12]
            end else if (tmrExpired) begin
               state_nxt = ST_WAIT_REL; // [R07]
            end
         end
         ST_WAIT_REL: begin
            // operator must return to run before selecting
            if (!resetDb && runDb) begin
               state_nxt = ST_SELECT; // [R07]
            end
         end
         ST_SELECT: begin
            if (tmrExpired) begin
               if (selOver_r || selCount_r == 2'h0) begin
                  state_nxt = ST_DO_RESET; // [R15]
               end else begin
                  state_nxt = ST_CONFIRM; // [R10]
               end
            end
         end
         ST_CONFIRM: begin
            if (resetRise) begin
               state_nxt = ST_DO_RESET; // [R11]
            end else if (tmrExpired) begin
               state_nxt = ST_DO_RESET; // [R12]
            end
         end
         ST_DO_RESET: begin
            state_nxt = ST_IDLE; // [R06]
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // sequencer registers and commands
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         resetPrev_r <= 1'b0;
         selCount_r <= 2'h0;
         selOver_r <= 1'b0;
         resetPulse <= 1'b0;
         extFunction <= `PRSRS_FUNC_NONE;
         extFunctionPulse <= 1'b0;
         running_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         resetPrev_r <= resetDb;
         resetPulse <= 1'b0;
         extFunctionPulse <= 1'b0;
         // presses counted only inside the selection window
         if (state_r == ST_SELECT && resetRise) begin
            if (selCount_r == 2'h2) begin
               selOver_r <= 1'b1; // [R15]
            end else begin
               selCount_r <= selCount_r + 2'h1; // [R08]
            end
         end
         if (state_r == ST_WAIT_REL) begin
            selCount_r <= 2'h0;
            selOver_r <= 1'b0;
         end
         if (state_r == ST_SELECT && tmrExpired) begin
            // function code latched for confirmation
            extFunction <= (selCount_r == 2'h2) ? `PRSRS_FUNC_RELOAD_PROJECT :
                           (selCount_r == 2'h1) ? `PRSRS_FUNC_ERASE_BLOCKS :
                           `PRSRS_FUNC_NONE; // [R08]
         end
         if (state_r == ST_CONFIRM && resetRise) begin
            extFunctionPulse <= 1'b1; // [R11]
         end
         if (state_r == ST_DO_RESET) begin
            resetPulse <= 1'b1; // [R06]
            running_r <= 1'b1; // [R06]
         end else if (state_r == ST_IDLE && haltDb) begin
            running_r <= 1'b0; // [R04]
         end else if (state_r == ST_IDLE && runDb) begin
            running_r <= 1'b1; // [R05]
         end
      end
   end

   // acknowledge flashes: two half-pulses per flash
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ackLeft_r <= 3'h0;
         ackCnt_r <= 32'h00000000;
      end else if (state_r == ST_SELECT && resetFall && !selOver_r && selCount_r != 2'h0) begin
         // restart ack for the count reached so far, lamp dark first;
         // an even load makes the first half-pulse a dark one, so one
         // press gives one flash and two presses give a double flash
         ackLeft_r <= (selCount_r == 2'h2) ? 3'h4 : 3'h2; // [R09]
         ackCnt_r <= ACK_CYC;
      end else if (state_r != ST_SELECT) begin
         ackLeft_r <= 3'h0;
         ackCnt_r <= 32'h00000000;
      end else if (ackLeft_r != 3'h0) begin
         if (ackCnt_r == 32'h00000000) begin
            ackLeft_r <= ackLeft_r - 3'h1;
            ackCnt_r <= ACK_CYC;
         end else begin
            ackCnt_r <= ackCnt_r - 32'h00000001;
         end
      end
   end

   // fault blink generator, half periods restart dark at each fault
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flashCnt_r <= 32'h00000000;
         blink_r <= 1'b0;
      end else if (!faultState) begin
         flashCnt_r <= 32'h00000000;
         blink_r <= 1'b0;
      end else if (flashCnt_r >= HALF_FLASH_CYC - 1) begin
         flashCnt_r <= 32'h00000000;
         blink_r <= ~blink_r; // [R01]
      end else begin
         flashCnt_r <= flashCnt_r + 32'h00000001;
      end
   end

   // lamps and execution enable
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         faultLamp <= 1'b0;
         haltLamp <= 1'b0;
         runLamp <= 1'b0;
         extendedFunctionLamp <= 1'b0;
         cycleEnable <= 1'b0;
      end else begin
         faultLamp <= faultState & blink_r; // [R01]
         haltLamp <= ~running_r; // [R02]
         cycleEnable <= running_r & ~faultState; // [R04] [R05]
         if (!running_r) begin
            runLamp <= 1'b0; // [R03]
         end else if (outputImageStart) begin
            runLamp <= 1'b1; // [R03]
         end else if (inputImageDone) begin
            runLamp <= 1'b0; // [R03]
         end
         // odd ack counts are the lit halves
         case (state_r)
            ST_WAIT_REL: extendedFunctionLamp <= 1'b1; // [R07]
            ST_SELECT: extendedFunctionLamp <= ackLeft_r[0]; // [R09]
            ST_CONFIRM: extendedFunctionLamp <= 1'b1; // [R10]
            default: extendedFunctionLamp <= 1'b0;
         endcase
      end
   end

   // battery monitor; report is sticky until power-on reset
   // the pin is asynchronous, so logic reads only the second stage;
   // a pin that recovers never clears the report on its own
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         batSync_r <= 2'h0;
         batteryError <= 1'b0;
         errCode <= 16'h0000;
         errModule <= 8'h00;
         errNumber <= 8'h00;
      end else begin
         batSync_r <= {batSync_r[0], batteryLow};
         if (batSync_r[1]) begin
            batteryError <= 1'b1; // [R13]
            errCode <= `PRSRS_ERR_CODE; // [R13]
            errModule <= `PRSRS_ERR_MODULE;
            errNumber <= `PRSRS_ERR_NUMBER;
         end
      end
   end
endmodule // prsrs_panel

/* File: prsrs_panel_chk.sv */
// assertion checker for the panel sequencer ports
`timescale 1ns/10ps
module prsrs_panel_chk #(
   parameter HALF_FLASH_CYC = 10
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // fault status
   input wire faultState,
   // lamps
   input wire faultLamp,
   input wire haltLamp,
   input wire runLamp,
   input wire extendedFunctionLamp,
   // commands and report
   input wire cycleEnable,
   input wire resetPulse,
   input wire [1:0] extFunction,
   input wire extFunctionPulse,
   input wire batteryError,
   input wire [15:0] errCode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // cycles the fault lamp has held; armed only after a toggle in fault,
   // since the first phase after the fault starts also counts dark cycles from before it
   reg [31:0] hold_r;
   reg last_r;
   reg armed_r;
   wire flip = faultLamp != last_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_r <= 32'h0;
         last_r <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         hold_r <= flip ? 32'h0 : hold_r + 32'h1;
         last_r <= faultLamp;
         armed_r <= faultState & (armed_r | flip);
      end
   end
   // confirmed function, then the controller reset
   sequence sExecThenReset;
      extFunctionPulse ##1 resetPulse;
   endsequence
   chk_reset_single: assert property (resetPulse |=> !resetPulse)
      else $error("reset pulse too long");
   chk_exec_reset: assert property (extFunctionPulse |-> sExecThenReset)
      else $error("no reset after function");
   chk_exec_window:
      assert property (extFunctionPulse |-> $past(extendedFunctionLamp, 2))
      else $error("function outside window");
   chk_halt_lamp: assert property (cycleEnable |-> !haltLamp)
      else $error("halt lamp while running");
   chk_run_dark: assert property (haltLamp |-> !runLamp)
      else $error("run lamp while halted");
   chk_blink_hold:
      assert property (armed_r && faultState |-> hold_r < HALF_FLASH_CYC)
      else $error("fault lamp held too long");
   chk_blink_edge:
      assert property (armed_r && faultState && flip |-> hold_r == HALF_FLASH_CYC - 1)
      else $error("fault lamp toggled early");
   chk_batt_report:
      assert property (batteryError |=> batteryError && errCode == 16'h0B00)
      else $error("battery report wrong");
endmodule // prsrs_panel_chk
bind prsrs_panel prsrs_panel_chk #(.HALF_FLASH_CYC(HALF_FLASH_CYC)) chk_u (.clk(clk),
   .rst_n(rst_n), .faultState(faultState), .faultLamp(faultLamp), .haltLamp(haltLamp),
   .runLamp(runLamp), .extendedFunctionLamp(extendedFunctionLamp),
   .cycleEnable(cycleEnable), .resetPulse(resetPulse), .extFunction(extFunction),
   .extFunctionPulse(extFunctionPulse), .batteryError(batteryError), .errCode(errCode));

/* File: prsrs_operator.sv */
// operator model: three-position switch with contact chatter
`timescale 1ns/10ps
module prsrs_operator (
   // clock
   input wire clk,
   // contacts, high in that position
   output reg haltPosition,
   output reg runPosition,
   output reg resetPosition
);
   // rests in run until moved
   initial begin
      haltPosition = 1'b0;
      runPosition = 1'b1;
      resetPosition = 1'b0;
   end
   // move lever to pos (0 halt, 1 run, 2 reset), then hold
   task move(input [1:0] pos, input integer hold);
      integer i;
      begin
         // one-cycle bursts, shorter than any debounce
         for (i = 0; i < 6; i = i + 1) begin
            @(posedge clk);
            {haltPosition, runPosition, resetPosition} <= i[0] ? 3'h4 >> pos : 3'h0;
         end
         repeat (hold) @(posedge clk);
      end
   endtask
endmodule // prsrs_operator

/* File: tb_prsrs_panel.sv */
// self-checking bench for the panel sequencer
`timescale 1ns/10ps
module tb_prsrs_panel;
   // stimulus and observed ports
   reg clk, rst_n, faultState, inputImageDone, outputImageStart, batteryLow;
   wire haltPosition, runPosition, resetPosition, faultLamp, haltLamp, runLamp;
   wire extendedFunctionLamp, cycleEnable, resetPulse, extFunctionPulse, batteryError;
   wire [1:0] extFunction;
   wire [15:0] errCode;
   wire [7:0] errModule, errNumber;
   // tallies
   integer nMismatch, nChecks, nRst, nExt, nRise, i, k, s, r0, e0;
   reg [1:0] lastFn;
   reg lampPrev, lampF;
   // rows: done, start, lamp / presses, confirm, function
   reg [2:0] rows [0:5];
   reg [4:0] xrows [0:4];
   // timing shrunk so every scenario fits the run budget
   localparam T_LONG = 50;
   localparam T_SEL = 400;
   localparam T_CONF = 200;
   localparam T_HALF = 10;
   localparam T_ACK = 5;
   localparam T_DEB = 3;
   prsrs_panel #(.LONG_PRESS_CYC(T_LONG), .SELECT_CYC(T_SEL), .CONFIRM_CYC(T_CONF),
      .HALF_FLASH_CYC(T_HALF), .ACK_CYC(T_ACK), .DEBOUNCE_CYC(T_DEB)) dut_u (
      .clk(clk), .rst_n(rst_n), .haltPosition(haltPosition), .runPosition(runPosition),
      .resetPosition(resetPosition), .faultState(faultState),
      .inputImageDone(inputImageDone), .outputImageStart(outputImageStart),
      .batteryLow(batteryLow), .faultLamp(faultLamp), .haltLamp(haltLamp),
      .runLamp(runLamp), .extendedFunctionLamp(extendedFunctionLamp),
      .cycleEnable(cycleEnable), .resetPulse(resetPulse), .extFunction(extFunction),
      .extFunctionPulse(extFunctionPulse), .batteryError(batteryError),
      .errCode(errCode), .errModule(errModule), .errNumber(errNumber));
   prsrs_operator op_u (.clk(clk), .haltPosition(haltPosition),
      .runPosition(runPosition), .resetPosition(resetPosition));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // pulse and flash tally
   always @(posedge clk) begin
      if (resetPulse === 1'b1)
         nRst = nRst + 1;
      if (extFunctionPulse === 1'b1) begin
         nExt = nExt + 1;
         lastFn = extFunction;
      end
      if (extendedFunctionLamp === 1'b1 && lampPrev !== 1'b1)
         nRise = nRise + 1;
      lampPrev = extendedFunctionLamp;
   end
   task chk(input string nm, input [15:0] ex, input [15:0] got);
      begin
         nChecks = nChecks + 1;
         if (got !== ex) begin
            nMismatch = nMismatch + 1;
            $display("Error %0s expected %0h seen %0h", nm, ex, got);
         end
      end
   endtask
   task conclude;
      begin
         if (nMismatch == 0 && nChecks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // outputs must sit at zero while reset is held
   task doReset;
      begin
         rst_n <= 1'b0;
         repeat (10) @(posedge clk);
         chk("rstOut", 0, {faultLamp, haltLamp, runLamp, extendedFunctionLamp,
            cycleEnable, resetPulse, extFunction, extFunctionPulse, batteryError});
         rst_n <= 1'b1;
         repeat (4) @(posedge clk);
         chk("haltLamp", 1, haltLamp);
      end
   endtask
   task tap;
      begin
         op_u.move(2'h2, 20);
         op_u.move(2'h1, 20);
      end
   endtask
   // long press, np selection presses, then confirm or let it lapse
   task extSeq(input [1:0] np, input cf, input [1:0] fn);
      begin
         r0 = nRst;
         e0 = nExt;
         op_u.move(2'h2, 80);
         chk("lampLong", 1, extendedFunctionLamp);
         op_u.move(2'h1, 20);
         chk("lampSel", 0, extendedFunctionLamp);
         nRise = 0;
         for (k = 0; k < np; k = k + 1) begin
            op_u.move(2'h2, 15);
            op_u.move(2'h1, 40);
         end
         if (np < 3)
            chk("flashes", np == 2 ? 3 : np, nRise);
         // a steady lamp for 20 cycles is longer than any flash
         s = 0;
         for (k = 0; k < 700 && s < 20 && nRst == r0; k = k + 1) begin
            @(posedge clk);
            s = extendedFunctionLamp === 1'b1 ? s + 1 : 0;
         end
         if (k == 700) begin
            nMismatch = nMismatch + 1;
            conclude;
         end
         chk("window", np == 1 || np == 2, s >= 20);
         if (cf) begin
            op_u.move(2'h2, 15);
            op_u.move(2'h1, 30);
         end else
            repeat (260) @(posedge clk);
         chk("extPulse", cf, nExt - e0);
         if (cf)
            chk("extFn", fn, lastFn);
         chk("rstCnt", 1, nRst - r0);
      end
   endtask
   initial begin
      nMismatch = 0;
      nChecks = 0;
      nRst = 0;
      nExt = 0;
      nRise = 0;
      lampPrev = 1'b0;
      lastFn = 2'h0;
      {rst_n, faultState, inputImageDone, outputImageStart, batteryLow} = 5'h00;
      {rows[0], rows[1], rows[2], rows[3], rows[4], rows[5]} = 18'h1C0CF;
      {xrows[0], xrows[1], xrows[2], xrows[3], xrows[4]} = 25'h0DB2018;
      doReset;
      tap;
      chk("rstCnt", 1, nRst);
      chk("running", 1, cycleEnable);
      for (i = 0; i < 6; i = i + 1) begin
         {inputImageDone, outputImageStart} <= rows[i][2:1];
         @(posedge clk);
         {inputImageDone, outputImageStart} <= 2'h0;
         @(negedge clk);
         chk("runLamp", rows[i][0], runLamp);
         @(posedge clk);
      end
      faultState <= 1'b1;
      repeat (30) @(posedge clk);
      @(negedge clk);
      lampF = faultLamp;
      s = 0;
      for (k = 0; k < 80; k = k + 1) begin
         @(negedge clk);
         s = s + (faultLamp !== lampF);
         lampF = faultLamp;
      end
      chk("blinks", 8, s);
      @(posedge clk);
      faultState <= 1'b0;
      batteryLow <= 1'b1;
      repeat (8) @(posedge clk);
      batteryLow <= 1'b0;
      repeat (8) @(posedge clk);
      chk("errCode", 16'h0B00, errCode);
      chk("errMod", 16'h0078, errModule);
      chk("errNum", 16'h0001, errNumber);
      for (i = 0; i < 5; i = i + 1)
         extSeq(xrows[i][4:3], xrows[i][2], xrows[i][1:0]);
      op_u.move(2'h0, 20);
      chk("halted", 0, cycleEnable);
      chk("haltLamp", 1, haltLamp);
      r0 = nRst;
      tap;
      chk("restart", 1, cycleEnable);
      chk("restartRst", 1, nRst - r0);
      doReset;
      conclude;
   end
endmodule // tb_prsrs_panel
